// ### core/can_selective_wake_filter_cfg.sv
// Transceiver status flags and wake-frame identifier filter with SPI register access
//
// Functional notes
// - LIN supply flag set only by LIN undervoltage in Normal mode; held until Normal mode is left, then zero.
// - CAN supply flag set by CAN supply undervoltage in Normal mode, mode 01/11.
// - CAN undervoltage detection runs only in Normal mode with mode 01/11.
// - CAN failure flag set when transmit input stays dominant past time-out.
// - Three-bit rate code selects wake decode bit rate, 50 to 1000 kbit/s.
// - Reserved rate codes 100 and 110 select 500 kbit/s.
// - Extended identifier spread over four byte registers from 27h to 2Ah.
// - Standard identifier bits 5..0 in byte2 7:2, bits 10..6 in byte3 4:0.
// - Identifier mask in 2Bh to 2Eh with the same layout as identifier.
// - Standard mask bits 5..0 at 2Dh 7:2, bits 10..6 at 2Eh 4:0.
// - Frame control bit 7 selects standard or extended identifier format.
// - CAN mode field: offline, active, active without undervoltage, listen-only.
`timescale 1ns/1ps
module can_selective_wake_filter_cfg (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	// SPI pins
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Chip state from the mode controller
	input wire logic normal_mode,
	input wire logic [1:0] can_mode_field,
	// Analog comparators and transmit pin
	input wire logic lin_supply_uv,
	input wire logic can_supply_uv,
	input wire logic can_transmit_input,
	// Transceiver control
	output logic lin_force_offline,
	output logic can_tx_enable,
	// Received frame identifier from the bus decoder
	input wire logic [28:0] rx_ident,
	input wire logic rx_ident_ext,
	input wire logic rx_ident_valid,
	// Filter results
	output logic wake_match,
	output logic [15:0] wake_bit_cycles,
	output wake_filter_pkg::filter_cfg_s filter_cfg,
	output wake_filter_pkg::status_s status
);
	wake_filter_pkg::reg_req_s req;
	logic [7:0] rd_data;
	logic [2:0] pin_raw;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pin;
	logic lin_uv;
	logic can_uv;
	logic txd_recessive;
	logic uv_det_active;
	logic tx_mode_active;
	logic [12:0] dom_cnt;
	logic [28:0] ref_ident;
	logic [28:0] ref_mask;
	logic [28:0] bit_ok;
	logic lin_supply_flag, can_supply_flag, can_failure_flag;

	// ****************************************
	// SPI access
	// ****************************************
	spi_reg_port u_spi (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.spi_cs_n(spi_cs_n),
		.spi_sck(spi_sck),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe),
		.req(req),
		.rd_data(rd_data)
	);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Comparator outputs may chatter; a change counts only when two stages agree
	assign pin_raw = {can_transmit_input, can_supply_uv, lin_supply_uv};
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				sync1[i] <= wake_filter_pkg::PIN_IN_RST[i];
				sync2[i] <= wake_filter_pkg::PIN_IN_RST[i];
				sync3[i] <= wake_filter_pkg::PIN_IN_RST[i];
				pin[i] <= wake_filter_pkg::PIN_IN_RST[i];
			end else if (ce) begin
				sync1[i] <= pin_raw[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
				if (sync2[i] == sync3[i]) begin
					pin[i] <= sync3[i];
				end
			end
		end
	end
	assign lin_uv = pin[0];
	assign can_uv = pin[1];
	assign txd_recessive = pin[2];

	// ****************************************
	// Mode decode
	// ****************************************
	assign uv_det_active = normal_mode &&
		(can_mode_field == wake_filter_pkg::CAN_ACTIVE ||
		can_mode_field == wake_filter_pkg::CAN_LISTEN_ONLY);
	assign tx_mode_active = normal_mode &&
		(can_mode_field == wake_filter_pkg::CAN_ACTIVE ||
		can_mode_field == wake_filter_pkg::CAN_ACTIVE_NO_UV);

	// ****************************************
	// Supply flags
	// ****************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lin_supply_flag <= wake_filter_pkg::STATUS_RST.lin_supply_flag;
			can_supply_flag <= wake_filter_pkg::STATUS_RST.can_supply_flag;
		end else if (ce) begin
			// LIN stays offline until Normal mode is left
			if (normal_mode && lin_uv) begin
				lin_supply_flag <= 1'b1;
			end else if (!normal_mode) begin
				lin_supply_flag <= 1'b0;
			end
			can_supply_flag <= uv_det_active && can_uv;
		end
	end
	assign lin_force_offline = lin_supply_flag;
	assign status = {lin_supply_flag, can_supply_flag, can_failure_flag};

	// ****************************************
	// Transmit dominant time-out
	// ****************************************
	// Flag clears only once the transmit input is back to recessive
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dom_cnt <= 13'h0000;
			can_failure_flag <= wake_filter_pkg::STATUS_RST.can_failure_flag;
		end else if (ce) begin
			if (txd_recessive || !tx_mode_active) begin
				dom_cnt <= 13'h0000;
			end else if (dom_cnt != 13'(wake_filter_pkg::TXD_TIMEOUT_CYC)) begin
				dom_cnt <= dom_cnt + 13'h0001;
			end
			if (!txd_recessive && dom_cnt == 13'(wake_filter_pkg::TXD_TIMEOUT_CYC - 1)) begin
				can_failure_flag <= 1'b1;
			end else if (txd_recessive) begin
				can_failure_flag <= 1'b0;
			end
		end
	end
	assign can_tx_enable = tx_mode_active && !can_failure_flag;

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			filter_cfg <= wake_filter_pkg::CFG_RST;
		end else if (ce && req.wr) begin
			case (req.addr)
				wake_filter_pkg::ADDR_WAKE_BIT_RATE_SELECT: begin
					filter_cfg.wake_bit_rate_code <= req.wdata[wake_filter_pkg::RATE_CODE_MSB:0];
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_BYTE0: begin
					filter_cfg.ident_low_byte <= req.wdata;
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_BYTE1: begin
					filter_cfg.ident_byte1 <= req.wdata;
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_BYTE2: begin
					filter_cfg.ident_byte2 <= req.wdata;
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_BYTE3: begin
					filter_cfg.ident_top_bits <= req.wdata[wake_filter_pkg::TOP_BITS_MSB:0];
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE0: begin
					filter_cfg.mask_low_byte <= req.wdata;
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE1: begin
					filter_cfg.mask_byte1 <= req.wdata;
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE2: begin
					filter_cfg.mask_byte2 <= req.wdata;
				end
				wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE3: begin
					filter_cfg.mask_top_bits <= req.wdata[wake_filter_pkg::TOP_BITS_MSB:0];
				end
				wake_filter_pkg::ADDR_WAKE_FRAME_CONTROL: begin
					filter_cfg.ident_format <= req.wdata[wake_filter_pkg::IDENT_FORMAT_BIT];
				end
				default: begin
					filter_cfg <= filter_cfg;
				end
			endcase
		end
	end

	// ****************************************
	// Read-back
	// ****************************************
	always_comb begin
		rd_data = 8'h00;
		case (req.addr)
			wake_filter_pkg::ADDR_TRANSCEIVER_STATUS: rd_data = {5'h00, status};
			wake_filter_pkg::ADDR_WAKE_BIT_RATE_SELECT: rd_data = {5'h00, filter_cfg.wake_bit_rate_code};
			wake_filter_pkg::ADDR_WAKE_IDENT_BYTE0: rd_data = filter_cfg.ident_low_byte;
			wake_filter_pkg::ADDR_WAKE_IDENT_BYTE1: rd_data = filter_cfg.ident_byte1;
			wake_filter_pkg::ADDR_WAKE_IDENT_BYTE2: rd_data = filter_cfg.ident_byte2;
			wake_filter_pkg::ADDR_WAKE_IDENT_BYTE3: rd_data = {3'h0, filter_cfg.ident_top_bits};
			wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE0: rd_data = filter_cfg.mask_low_byte;
			wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE1: rd_data = filter_cfg.mask_byte1;
			wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE2: rd_data = filter_cfg.mask_byte2;
			wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE3: rd_data = {3'h0, filter_cfg.mask_top_bits};
			wake_filter_pkg::ADDR_WAKE_FRAME_CONTROL: rd_data = {filter_cfg.ident_format, 7'h00};
			default: rd_data = 8'h00;
		endcase
	end

	// ****************************************
	// Bit rate
	// ****************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wake_bit_cycles <= wake_filter_pkg::CYC_50K;
		end else if (ce) begin
			case (filter_cfg.wake_bit_rate_code)
				3'h0: wake_bit_cycles <= wake_filter_pkg::CYC_50K;
				3'h1: wake_bit_cycles <= wake_filter_pkg::CYC_100K;
				3'h2: wake_bit_cycles <= wake_filter_pkg::CYC_125K;
				3'h3: wake_bit_cycles <= wake_filter_pkg::CYC_250K;
				3'h7: wake_bit_cycles <= wake_filter_pkg::CYC_1000K;
				default: wake_bit_cycles <= wake_filter_pkg::CYC_500K;
			endcase
		end
	end

	// ****************************************
	// Identifier match
	// ****************************************
	// Standard format forces the unused upper bits to don't care
	always_comb begin
		if (filter_cfg.ident_format) begin
			ref_ident = {filter_cfg.ident_top_bits, filter_cfg.ident_byte2,
				filter_cfg.ident_byte1, filter_cfg.ident_low_byte};
			ref_mask = {filter_cfg.mask_top_bits, filter_cfg.mask_byte2,
				filter_cfg.mask_byte1, filter_cfg.mask_low_byte};
		end else begin
			ref_ident = {18'h00000, filter_cfg.ident_top_bits,
				filter_cfg.ident_byte2[7:wake_filter_pkg::STD_LOW_LSB]};
			ref_mask = {18'h3FFFF, filter_cfg.mask_top_bits,
				filter_cfg.mask_byte2[7:wake_filter_pkg::STD_LOW_LSB]};
		end
	end
	for (genvar b = 0; b < 29; b++) begin : g_match
		assign bit_ok[b] = ref_mask[b] || (rx_ident[b] == ref_ident[b]);
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wake_match <= 1'b0;
		end else if (ce) begin
			wake_match <= rx_ident_valid && (rx_ident_ext == filter_cfg.ident_format) &&
				(&bit_ok);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	lin_flag_clear_a: assert property (
		ce && !normal_mode |=> !status.lin_supply_flag)
		else $error("LIN supply flag set outside Normal mode");
	can_supply_set_a: assert property (
		ce && normal_mode && can_mode_field == 2'h3 && can_uv |=> status.can_supply_flag)
		else $error("CAN supply flag missed undervoltage");
	can_supply_off_a: assert property (
		ce && can_mode_field == 2'h2 |=> !status.can_supply_flag)
		else $error("CAN supply flag set with detection off");
	tx_timeout_a: assert property (
		ce && tx_mode_active && !txd_recessive && dom_cnt == 13'(wake_filter_pkg::TXD_TIMEOUT_CYC - 1)
		|=> status.can_failure_flag && !can_tx_enable)
		else $error("Dominant time-out did not disable transmitter");
	rate_top_a: assert property (
		ce && filter_cfg.wake_bit_rate_code == 3'h7 |=> wake_bit_cycles == 16'h0032)
		else $error("Top rate code not 1000 kbit/s");
	rate_reserved_a: assert property (
		ce && filter_cfg.wake_bit_rate_code[2] && !filter_cfg.wake_bit_rate_code[0]
		|=> wake_bit_cycles == 16'h0064)
		else $error("Reserved rate code not 500 kbit/s");
	ident_top_wr_a: assert property (
		ce && req.wr && req.addr == wake_filter_pkg::ADDR_WAKE_IDENT_BYTE3
		|=> filter_cfg.ident_top_bits == $past(req.wdata[4:0]))
		else $error("Identifier top bits not written");
	std_match_a: assert property (
		ce && rx_ident_valid && !rx_ident_ext && !filter_cfg.ident_format &&
		rx_ident[10:0] == {filter_cfg.ident_top_bits, filter_cfg.ident_byte2[7:2]}
		|=> wake_match)
		else $error("Standard identifier did not match");
	mask_top_wr_a: assert property (
		ce && req.wr && req.addr == wake_filter_pkg::ADDR_WAKE_IDENT_MASK_BYTE3
		|=> filter_cfg.mask_top_bits == $past(req.wdata[4:0]))
		else $error("Mask top bits not written");
	std_mask_a: assert property (
		ce && rx_ident_valid && !rx_ident_ext && !filter_cfg.ident_format &&
		filter_cfg.mask_top_bits == 5'h1F && filter_cfg.mask_byte2[7:2] == 6'h3F
		|=> wake_match)
		else $error("Fully masked standard frame did not match");
	format_a: assert property (
		ce && rx_ident_ext != filter_cfg.ident_format |=> !wake_match)
		else $error("Wrong identifier format matched");
	listen_tx_a: assert property (
		can_mode_field == 2'h3 || can_mode_field == 2'h0 |-> !can_tx_enable)
		else $error("Transmitter on in offline or listen-only mode");
	reserved_rd_a: assert property (
		req.addr == 7'h2E || req.addr == 7'h2A |-> rd_data[7:5] == 3'h0)
		else $error("Reserved bits read non-zero");
	status_wr_a: assert property (
		ce && req.wr && req.addr == wake_filter_pkg::ADDR_TRANSCEIVER_STATUS
		|=> filter_cfg == $past(filter_cfg))
		else $error("Status write changed configuration");
	masked_bit_a: assert property (
		ce && rx_ident_valid && rx_ident_ext && filter_cfg.ident_format &&
		$onehot(rx_ident ^ ref_ident) && |((rx_ident ^ ref_ident) & ref_mask) |=> wake_match)
		else $error("Masked bit affected match");

	ext_match_c: cover property (ce && rx_ident_valid && rx_ident_ext ##1 wake_match);
	std_match_c: cover property (ce && rx_ident_valid && !rx_ident_ext ##1 wake_match);
	tx_fail_c: cover property (!status.can_failure_flag ##1 status.can_failure_flag);
	lin_off_c: cover property (!status.lin_supply_flag ##1 status.lin_supply_flag);

endmodule : can_selective_wake_filter_cfg

// ### common/wake_filter_pkg.sv
// Package: register map, field layout, reset values, timing and carriers of the wake filter
package wake_filter_pkg;

	// ****************************************
	// Register offsets (7-bit register address)
	// ****************************************
	localparam logic [6:0] ADDR_TRANSCEIVER_STATUS = 7'h22;
	localparam logic [6:0] ADDR_WAKE_BIT_RATE_SELECT = 7'h26;
	localparam logic [6:0] ADDR_WAKE_IDENT_BYTE0 = 7'h27;
	localparam logic [6:0] ADDR_WAKE_IDENT_BYTE1 = 7'h28;
	localparam logic [6:0] ADDR_WAKE_IDENT_BYTE2 = 7'h29;
	localparam logic [6:0] ADDR_WAKE_IDENT_BYTE3 = 7'h2A;
	localparam logic [6:0] ADDR_WAKE_IDENT_MASK_BYTE0 = 7'h2B;
	localparam logic [6:0] ADDR_WAKE_IDENT_MASK_BYTE1 = 7'h2C;
	localparam logic [6:0] ADDR_WAKE_IDENT_MASK_BYTE2 = 7'h2D;
	localparam logic [6:0] ADDR_WAKE_IDENT_MASK_BYTE3 = 7'h2E;
	localparam logic [6:0] ADDR_WAKE_FRAME_CONTROL = 7'h2F;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int LIN_SUPPLY_FLAG_BIT = 2;
	localparam int CAN_SUPPLY_FLAG_BIT = 1;
	localparam int CAN_FAILURE_FLAG_BIT = 0;
	localparam int RATE_CODE_MSB = 2;
	localparam int TOP_BITS_MSB = 4;
	localparam int STD_LOW_LSB = 2;
	localparam int IDENT_FORMAT_BIT = 7;
	localparam int SPI_FRAME_BITS = 16;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [1:0] {
		CAN_OFFLINE = 2'h0,
		CAN_ACTIVE = 2'h1,
		CAN_ACTIVE_NO_UV = 2'h2,
		CAN_LISTEN_ONLY = 2'h3
	} can_mode_e;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int TXD_TIMEOUT_US = 60;
	localparam int TXD_TIMEOUT_CYC = (TXD_TIMEOUT_US * (CLK_HZ / 1_000_000));
	localparam logic [15:0] CYC_50K = 16'(CLK_HZ / 50_000);
	localparam logic [15:0] CYC_100K = 16'(CLK_HZ / 100_000);
	localparam logic [15:0] CYC_125K = 16'(CLK_HZ / 125_000);
	localparam logic [15:0] CYC_250K = 16'(CLK_HZ / 250_000);
	localparam logic [15:0] CYC_500K = 16'(CLK_HZ / 500_000);
	localparam logic [15:0] CYC_1000K = 16'(CLK_HZ / 1_000_000);

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic ident_format;
		logic [2:0] wake_bit_rate_code;
		logic [TOP_BITS_MSB:0] ident_top_bits;
		logic [7:0] ident_byte2;
		logic [7:0] ident_byte1;
		logic [7:0] ident_low_byte;
		logic [TOP_BITS_MSB:0] mask_top_bits;
		logic [7:0] mask_byte2;
		logic [7:0] mask_byte1;
		logic [7:0] mask_low_byte;
	} filter_cfg_s;

	typedef struct packed {
		logic lin_supply_flag;
		logic can_supply_flag;
		logic can_failure_flag;
	} status_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// ****************************************
	// Reset values
	// ****************************************
	localparam filter_cfg_s CFG_RST = '0;
	localparam status_s STATUS_RST = '0;
	localparam logic [2:0] SPI_PIN_RST = 3'h4;
	localparam logic [2:0] PIN_IN_RST = 3'h4;

endpackage : wake_filter_pkg

// ### core/spi_reg_port.sv
// SPI slave that turns 16-bit frames into register read and write requests
`timescale 1ns/1ps
module spi_reg_port (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	// SPI pins
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Register side
	output wake_filter_pkg::reg_req_s req,
	input wire logic [7:0] rd_data
);
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_ADDR = 2'b01,
		SPI_DATA = 2'b11,
		SPI_HOLD = 2'b10
	} spi_state_e;

	logic [2:0] pin_raw;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pin;
	logic [2:0] pin_q;
	logic sck_rise;
	logic sck_fall;
	logic cs_active;
	spi_state_e state;
	logic [3:0] bit_cnt;
	logic [6:0] shift_in;
	logic [7:0] shift_out;
	logic read_frame;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// A level counts once the second and third stage agree
	assign pin_raw = {spi_cs_n, spi_sck, spi_sdi};
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				sync1[i] <= wake_filter_pkg::SPI_PIN_RST[i];
				sync2[i] <= wake_filter_pkg::SPI_PIN_RST[i];
				sync3[i] <= wake_filter_pkg::SPI_PIN_RST[i];
				pin[i] <= wake_filter_pkg::SPI_PIN_RST[i];
				pin_q[i] <= wake_filter_pkg::SPI_PIN_RST[i];
			end else if (ce) begin
				sync1[i] <= pin_raw[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
				if (sync2[i] == sync3[i]) begin
					pin[i] <= sync3[i];
				end
				pin_q[i] <= pin[i];
			end
		end
	end

	assign cs_active = !pin[2];
	assign sck_rise = ce && cs_active && pin[1] && !pin_q[1];
	assign sck_fall = ce && cs_active && !pin[1] && pin_q[1];
	assign spi_sdo_oe = cs_active;

	// ****************************************
	// Frame sequencer
	// ****************************************
	// Writes commit only on the sixteenth edge, so a short frame changes nothing
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= SPI_IDLE;
			bit_cnt <= 4'h0;
			shift_in <= 7'h00;
			read_frame <= 1'b0;
			req <= '0;
		end else if (ce) begin
			req.wr <= 1'b0;
			req.rd <= 1'b0;
			if (!cs_active) begin
				state <= SPI_IDLE;
				bit_cnt <= 4'h0;
			end else begin
				if (state == SPI_IDLE) begin
					state <= SPI_ADDR;
				end
				if (sck_rise) begin
					shift_in <= {shift_in[5:0], pin[0]};
					bit_cnt <= bit_cnt + 4'h1;
					case (state)
						SPI_IDLE, SPI_ADDR: begin
							if (bit_cnt == 4'h7) begin
								req.addr <= shift_in;
								req.rd <= 1'b1;
								read_frame <= pin[0];
								state <= SPI_DATA;
							end
						end
						SPI_DATA: begin
							if (bit_cnt == 4'(wake_filter_pkg::SPI_FRAME_BITS - 1)) begin
								req.wdata <= {shift_in, pin[0]};
								req.wr <= !read_frame;
								state <= SPI_HOLD;
							end
						end
						SPI_HOLD: begin
							state <= SPI_HOLD;
						end
						default: begin
							state <= SPI_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// Read-back shifter
	// ****************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shift_out <= 8'h00;
			spi_sdo <= 1'b0;
		end else if (ce) begin
			if (req.rd) begin
				shift_out <= rd_data;
			end else if (sck_fall && state != SPI_ADDR) begin
				spi_sdo <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b0};
			end else if (!cs_active) begin
				spi_sdo <= 1'b0;
			end
		end
	end

endmodule : spi_reg_port

// ### sim/spi_host_model.sv
// Host microcontroller model that runs 16-bit SPI frames in mode 0
`timescale 1ns/1ps
module spi_host_model (
	// Clock
	input wire logic clk_sys,
	// SPI pins
	output logic spi_cs_n,
	output logic spi_sck,
	output logic spi_sdi,
	input wire logic spi_sdo,
	// Read result
	output logic done,
	output logic [7:0] rdata
);
	// ******
	// Frame engine
	// ******
	// Slow sck: the slave synchronises it, so it needs many system clocks per half period
	localparam int HALF = 10;
	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		spi_sdi = 1'b0;
		done = 1'b0;
		rdata = 8'h00;
	end
	task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] d);
		logic [15:0] f;
		f = {a, r, d};
		@(posedge clk_sys) spi_cs_n <= 1'b0;
		repeat (HALF) @(posedge clk_sys);
		for (int i = 15; i >= 0; i--) begin
			spi_sdi <= f[i];
			repeat (HALF) @(posedge clk_sys);
			spi_sck <= 1'b1;
			if (i < 8) rdata[i] <= spi_sdo;
			repeat (HALF) @(posedge clk_sys);
			spi_sck <= 1'b0;
		end
		repeat (HALF) @(posedge clk_sys);
		spi_cs_n <= 1'b1;
		// Released data line shows the inverse, never a stale bit
		spi_sdi <= ~f[0];
		done <= r;
		@(posedge clk_sys) done <= 1'b0;
		repeat (HALF) @(posedge clk_sys);
	endtask : xfer
endmodule : spi_host_model

// ### sim/test_can_selective_wake_filter_cfg.sv
// Self-checking bench: registers, rate table, identifier filter and status flags
`timescale 1ns/1ps
module test_can_selective_wake_filter_cfg;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic normal_mode = 1'b0, lin_supply_uv = 1'b0, can_supply_uv = 1'b0;
	logic can_transmit_input = 1'b1, rx_ident_ext = 1'b0, rx_ident_valid = 1'b0, v1 = 1'b0;
	logic [1:0] can_mode_field = 2'h0;
	logic [28:0] rx_ident = '0;
	logic spi_cs_n, spi_sck, spi_sdi, spi_sdo, lin_force_offline, can_tx_enable, wake_match, done;
	logic [7:0] rdata;
	logic spi_sdo_oe;
	logic [15:0] wake_bit_cycles;
	wake_filter_pkg::filter_cfg_s filter_cfg;
	wake_filter_pkg::status_s status;
	logic [7:0] rq[$];
	logic mq[$];
	int num_errors = 0, checks = 0, cyc = 0;
	logic [7:0] wv[15];
	logic [7:0] msk[15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h1F,
		8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h80, 8'h00};
	logic [15:0] rt[8] = '{wake_filter_pkg::CYC_50K, wake_filter_pkg::CYC_100K,
		wake_filter_pkg::CYC_125K, wake_filter_pkg::CYC_250K, wake_filter_pkg::CYC_500K,
		wake_filter_pkg::CYC_500K, wake_filter_pkg::CYC_500K, wake_filter_pkg::CYC_1000K};
	always #10 clk_sys = ~clk_sys;
	spi_host_model host (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .done(done), .rdata(rdata));
	can_selective_wake_filter_cfg dut (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
		.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .normal_mode(normal_mode), .can_mode_field(can_mode_field),
		.lin_supply_uv(lin_supply_uv), .can_supply_uv(can_supply_uv),
		.can_transmit_input(can_transmit_input), .lin_force_offline(lin_force_offline),
		.can_tx_enable(can_tx_enable), .rx_ident(rx_ident), .rx_ident_ext(rx_ident_ext),
		.rx_ident_valid(rx_ident_valid), .wake_match(wake_match),
		.wake_bit_cycles(wake_bit_cycles), .filter_cfg(filter_cfg), .status(status));
	// ******
	// Tasks
	// ******
	task automatic close_out;
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		rq.push_back(e);
		host.xfer(a, 1'b1, 8'h00);
	endtask : rd
	task automatic send(input logic [28:0] id, input logic ext, input logic e);
		mq.push_back(e);
		@(posedge clk_sys);
		rx_ident <= id;
		rx_ident_ext <= ext;
		rx_ident_valid <= 1'b1;
	endtask : send
	// Standard layout puts the 11 bits at 2Ah/29h; the low bytes get filler
	task automatic setf(input logic [28:0] r, input logic [28:0] m, input logic ext);
		logic [31:0] x;
		logic [31:0] y;
		x = ext ? {3'h0, r} : {3'h0, r[10:0], r[28:11]};
		y = ext ? {3'h0, m} : {3'h0, m[10:0], m[28:11]};
		host.xfer(7'h2F, 1'b0, {ext, 7'h00});
		for (int i = 0; i < 4; i++) begin
			host.xfer(7'h27 + 7'(i), 1'b0, x[8*i+:8]);
			host.xfer(7'h2B + 7'(i), 1'b0, y[8*i+:8]);
		end
		cmp(filter_cfg.ident_top_bits, x[28:24]);
		cmp(filter_cfg.mask_top_bits, y[28:24]);
		cmp(filter_cfg.ident_format, ext);
	endtask : setf
	// ******
	// Result watcher and timeout
	// ******
	always @(posedge clk_sys) begin
		v1 <= rx_ident_valid;
		if (v1) cmp(wake_match, mq.pop_front());
		if (done) cmp(rdata, rq.pop_front());
		if (spi_sck) cmp(spi_sdo_oe, 1'b1);
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		logic [28:0] r;
		logic [28:0] m;
		int k;
		void'($urandom(32'h7AF5));
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		for (int a = 0; a < 15; a++) rd(7'h22 + 7'(a), 8'h00);
		for (int a = 0; a < 15; a++) begin
			wv[a] = 8'($urandom);
			host.xfer(7'h22 + 7'(a), 1'b0, wv[a]);
		end
		for (int a = 0; a < 15; a++) rd(7'h22 + 7'(a), wv[a] & msk[a]);
		for (int c = 0; c < 8; c++) begin
			host.xfer(7'h26, 1'b0, 8'(c));
			cmp(wake_bit_cycles, rt[c]);
		end
		for (int e = 1; e >= 0; e--) begin
			r = 29'($urandom);
			k = $urandom % (e ? 29 : 11);
			m = 29'(1) << k;
			setf(r, m, e[0]);
			send(r ^ m, e[0], 1'b1);
			send(r ^ (29'(1) << ((k + 1) % (e ? 29 : 11))), e[0], 1'b0);
			send(r, ~e[0], 1'b0);
			send(r, e[0], 1'b1);
			@(posedge clk_sys);
			rx_ident_valid <= 1'b0;
			rx_ident <= ~rx_ident;
			repeat (3) @(posedge clk_sys);
		end
		// Fully masked standard identifier must match any received standard frame
		host.xfer(7'h2D, 1'b0, 8'hFC);
		host.xfer(7'h2E, 1'b0, 8'h1F);
		send(29'($urandom), 1'b0, 1'b1);
		@(posedge clk_sys);
		rx_ident_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		normal_mode <= 1'b1;
		can_supply_uv <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			can_mode_field <= 2'(c);
			repeat (8) @(posedge clk_sys);
			cmp(status.can_supply_flag, c == 1 || c == 3);
			cmp(can_tx_enable, c == 1 || c == 2);
		end
		lin_supply_uv <= 1'b1;
		repeat (8) @(posedge clk_sys);
		cmp({lin_force_offline, status.lin_supply_flag}, 2'b11);
		rd(7'h22, 8'h06);
		normal_mode <= 1'b0;
		lin_supply_uv <= 1'b0;
		can_supply_uv <= 1'b0;
		repeat (8) @(posedge clk_sys);
		cmp(status, 3'b000);
		normal_mode <= 1'b1;
		can_mode_field <= 2'h1;
		can_transmit_input <= 1'b0;
		repeat (2990) @(posedge clk_sys);
		cmp(status.can_failure_flag, 1'b0);
		repeat (20) @(posedge clk_sys);
		cmp({can_tx_enable, status}, 4'b0001);
		rd(7'h22, 8'h01);
		can_transmit_input <= 1'b1;
		repeat (8) @(posedge clk_sys);
		cmp(status.can_failure_flag, 1'b0);
		close_out;
	end
endmodule : test_can_selective_wake_filter_cfg
